// >>> rtl/lpc_defs.svh
`ifndef LPC_DEFS_SVH
`define LPC_DEFS_SVH
// register offsets (16-bit word addresses)
`define LPC_OFS_CODE_SEL 16'h0514
`define LPC_OFS_THRESH 16'h0515
`define LPC_OFS_MAXWAIT 16'h0518
`define LPC_OFS_PHYCTL 16'h0519
`define LPC_OFS_TEST 16'h0531
`define LPC_OFS_TRAIN 16'h0543
`define LPC_OFS_LINKSTAT 16'h0540
// reset values
`define LPC_RST_CODE_SEL 16'h08e3
`define LPC_RST_THRESH 16'h0808
`define LPC_RST_MAXWAIT 16'h17ce
`define LPC_RST_PHYCTL 16'h003d
`define LPC_RST_TEST 16'h0000
// writable bit masks
`define LPC_MSK_CODE_SEL 16'h0fff
`define LPC_MSK_THRESH 16'h7f7f
`define LPC_MSK_MAXWAIT 16'hffff
`define LPC_MSK_PHYCTL 16'h7fff
`define LPC_MSK_TEST 16'h01ff
// field positions
`define LPC_TXW_HI 11
`define LPC_TXW_LO 9
`define LPC_TXS_HI 8
`define LPC_TXS_LO 6
`define LPC_RXW_HI 5
`define LPC_RXW_LO 3
`define LPC_RXS_HI 2
`define LPC_RXS_LO 0
`define LPC_WTH_HI 14
`define LPC_WTH_LO 8
`define LPC_STH_HI 6
`define LPC_STH_LO 0
`define LPC_FRC_VAL 11
`define LPC_FRC_EN 10
`define LPC_MINW_HI 7
`define LPC_ORDER 8
`define LPC_TM7_HI 7
// timing: one timer unit is 16 us at a 40 ns clock
`define LPC_UNIT_US 16
`define LPC_CLK_NS 40
`define LPC_UNIT_CYC ((`LPC_UNIT_US * 1000) / `LPC_CLK_NS)
// one millisecond of training time
`define LPC_MS_CYC (1000000 / `LPC_CLK_NS)
`endif

// >>> rtl/lpc_pkg.sv
package lpc_pkg;
  typedef logic [15:0] lpc_word_t;
  typedef logic [2:0] lpc_code_t;
  typedef enum logic [1:0] {
    LPC_IDLE = 2'b00,
    LPC_MIN = 2'b01,
    LPC_MAX = 2'b11,
    LPC_DONE = 2'b10
  } lpc_wait_e;
endpackage : lpc_pkg

// >>> rtl/lpc_rep_det.sv
`timescale 1ns/100ps
`default_nettype none
// counts consecutive matching code groups and flags at threshold
module lpc_rep_det (
  input wire logic sys_clk, // core clock
  input wire logic reset, // async reset
  input wire logic clk_en, // clock enable
  input wire logic code_vld, // a code group arrives
  input wire lpc_pkg::lpc_code_t code_in, // received code group
  input wire lpc_pkg::lpc_code_t expect_code, // code to match
  input wire logic [6:0] threshold, // required run length
  output logic hit // command received pulse
);
  import lpc_pkg::*;
  logic [6:0] run_reg;
  logic match;
  assign match = code_vld && (code_in == expect_code);
  // run counter, restarts on any other code group
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      run_reg <= 7'h00;
    end else if (clk_en && code_vld) begin
      if (!match) begin
        run_reg <= 7'h00;
      end else if (run_reg != 7'h7f) begin
        run_reg <= run_reg + 7'h01;
      end
    end
  end
  // pulse once when the run reaches the threshold
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hit <= 1'b0;
    end else if (clk_en) begin
      hit <= match && (threshold != 7'h00) && (run_reg + 7'h01 == threshold);
    end
  end
endmodule : lpc_rep_det
`default_nettype wire

// >>> rtl/lpc_regs.sv
// Functional notes
// - send programmed wake code on wake
// - send programmed sleep code on sleep
// - receive wake code field marks wake
// - receive sleep code field marks sleep
// - wake flagged after threshold consecutive codes
// - sleep flagged after threshold consecutive codes
// - max wait timer, 16 us units
// - min wait timer, 16 us units
// - force enable replaces derived link status
// - forced value used only when enabled
// - test mode 4 symbol order select
// - test mode 7 sends programmed byte
// - training time in ms, read only
//
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "lpc_defs.svh"
module lpc_regs #(
  parameter int unsigned UNIT_CYC = `LPC_UNIT_CYC, // cycles per 16 us unit
  parameter int unsigned MS_CYC = `LPC_MS_CYC // cycles per millisecond
) (
  input wire logic sys_clk, // core clock, 25 MHz
  input wire logic reset, // async reset, active high
  input wire logic clk_en, // freezes all state when low
  input wire logic [15:0] reg_addr, // register word address
  input wire lpc_pkg::lpc_word_t reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output lpc_pkg::lpc_word_t reg_rdata, // read data, cycle after strobe
  input wire logic tx_wake_req, // datapath wants to signal wake
  input wire logic tx_sleep_req, // datapath wants to signal sleep
  input wire logic rx_code_vld, // received code group valid
  input wire lpc_pkg::lpc_code_t rx_code, // received code group
  input wire logic link_up_start, // begin link-up wait sequence
  input wire logic link_stat_raw, // derived link status
  input wire logic training_done, // link training finished
  input wire logic [1:0] test_mode_sel, // 0 off, 1 mode 4, 2 mode 7
  output logic tx_code_vld, // tx code group valid
  output lpc_pkg::lpc_code_t tx_code, // tx code group
  output logic rx_wake_cmd, // wake command received pulse
  output logic rx_sleep_cmd, // sleep command received pulse
  output logic minwait_done, // min wait elapsed
  output logic maxwait_expired, // max wait elapsed
  output logic link_stat, // effective link status
  output logic tm4_sym_t2, // test mode 4 symbol, 1 = T2
  output logic [7:0] tm7_data, // test mode 7 data byte
  output logic tm_active // a test pattern is being sent
);
  import lpc_pkg::*;
  lpc_word_t code_sel_reg, thresh_reg, maxwait_reg, phyctl_reg, test_reg;
  logic [7:0] train_ms_reg;
  logic [31:0] train_cyc_reg;
  logic training_reg;
  lpc_wait_e wait_reg;
  logic [15:0] unit_cnt_reg;
  logic [31:0] tick_reg;
  logic wake_hit, sleep_hit;
  logic unit_tick;
  logic tm4_on_reg; // mode 4 was selected last cycle
  lpc_word_t rd_next;

  // software writes, reserved bits masked
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      code_sel_reg <= `LPC_RST_CODE_SEL;
      thresh_reg <= `LPC_RST_THRESH;
      maxwait_reg <= `LPC_RST_MAXWAIT;
      phyctl_reg <= `LPC_RST_PHYCTL;
      test_reg <= `LPC_RST_TEST;
    end else if (clk_en && reg_wr) begin
      unique case (reg_addr)
        `LPC_OFS_CODE_SEL: code_sel_reg <= reg_wdata & `LPC_MSK_CODE_SEL;
        `LPC_OFS_THRESH: thresh_reg <= reg_wdata & `LPC_MSK_THRESH;
        `LPC_OFS_MAXWAIT: maxwait_reg <= reg_wdata & `LPC_MSK_MAXWAIT;
        `LPC_OFS_PHYCTL: phyctl_reg <= reg_wdata & `LPC_MSK_PHYCTL;
        `LPC_OFS_TEST: test_reg <= reg_wdata & `LPC_MSK_TEST;
        default: ;
      endcase
    end
  end

  // read mux, unmapped reads return zero
  always_comb begin
    rd_next = 16'h0000;
    unique case (reg_addr)
      `LPC_OFS_CODE_SEL: rd_next = code_sel_reg;
      `LPC_OFS_THRESH: rd_next = thresh_reg;
      `LPC_OFS_MAXWAIT: rd_next = maxwait_reg;
      `LPC_OFS_PHYCTL: rd_next = phyctl_reg;
      `LPC_OFS_TEST: rd_next = test_reg;
      `LPC_OFS_TRAIN: rd_next = {8'h00, train_ms_reg};
      `LPC_OFS_LINKSTAT: rd_next = {14'h0000, wait_reg == LPC_DONE, link_stat};
      default: rd_next = 16'h0000;
    endcase
  end

  // read data valid only the cycle after the strobe
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rd_next : 16'h0000;
    end
  end

  // transmit code group select, wake has priority
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tx_code_vld <= 1'b0;
      tx_code <= 3'h0;
    end else if (clk_en) begin
      tx_code_vld <= tx_wake_req || tx_sleep_req;
      if (tx_wake_req) begin
        tx_code <= code_sel_reg[`LPC_TXW_HI:`LPC_TXW_LO];
      end else if (tx_sleep_req) begin
        tx_code <= code_sel_reg[`LPC_TXS_HI:`LPC_TXS_LO];
      end else begin
        tx_code <= 3'h0;
      end
    end
  end

  lpc_rep_det u_wake_det (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .code_vld(rx_code_vld),
    .code_in(rx_code),
    .expect_code(code_sel_reg[`LPC_RXW_HI:`LPC_RXW_LO]),
    .threshold(thresh_reg[`LPC_WTH_HI:`LPC_WTH_LO]),
    .hit(wake_hit)
  );

  lpc_rep_det u_sleep_det (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .code_vld(rx_code_vld),
    .code_in(rx_code),
    .expect_code(code_sel_reg[`LPC_RXS_HI:`LPC_RXS_LO]),
    .threshold(thresh_reg[`LPC_STH_HI:`LPC_STH_LO]),
    .hit(sleep_hit)
  );

  // received command pulses
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rx_wake_cmd <= 1'b0;
      rx_sleep_cmd <= 1'b0;
    end else if (clk_en) begin
      rx_wake_cmd <= wake_hit;
      rx_sleep_cmd <= sleep_hit;
    end
  end

  // 16 us unit prescaler, runs while waiting
  assign unit_tick = (tick_reg == UNIT_CYC - 1);
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tick_reg <= 32'h0000_0000;
    end else if (clk_en) begin
      if (link_up_start || unit_tick || wait_reg == LPC_IDLE || wait_reg == LPC_DONE) begin
        tick_reg <= 32'h0000_0000;
      end else begin
        tick_reg <= tick_reg + 32'h0000_0001;
      end
    end
  end

  // link-up wait sequence: min wait then max wait
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wait_reg <= LPC_IDLE;
      unit_cnt_reg <= 16'h0000;
      minwait_done <= 1'b0;
      maxwait_expired <= 1'b0;
    end else if (clk_en) begin
      if (link_up_start) begin
        wait_reg <= LPC_MIN;
        unit_cnt_reg <= {8'h00, phyctl_reg[`LPC_MINW_HI:0]};
        minwait_done <= 1'b0;
        maxwait_expired <= 1'b0;
      end else begin
        unique case (wait_reg)
          LPC_IDLE, LPC_DONE: ;
          LPC_MIN: begin
            if (unit_cnt_reg == 16'h0000) begin
              wait_reg <= LPC_MAX;
              unit_cnt_reg <= maxwait_reg;
              minwait_done <= 1'b1;
            end else if (unit_tick) begin
              unit_cnt_reg <= unit_cnt_reg - 16'h0001;
            end
          end
          LPC_MAX: begin
            if (unit_cnt_reg == 16'h0000) begin
              wait_reg <= LPC_DONE;
              maxwait_expired <= 1'b1;
            end else if (unit_tick) begin
              unit_cnt_reg <= unit_cnt_reg - 16'h0001;
            end
          end
        endcase
      end
    end
  end

  // effective link status
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      link_stat <= 1'b0;
    end else if (clk_en) begin
      link_stat <= phyctl_reg[`LPC_FRC_EN] ? phyctl_reg[`LPC_FRC_VAL] : link_stat_raw;
    end
  end

  // test mode pattern outputs
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tm4_on_reg <= 1'b0;
      tm4_sym_t2 <= 1'b0;
      tm7_data <= 8'h00;
      tm_active <= 1'b0;
    end else if (clk_en) begin
      tm_active <= (test_mode_sel == 2'h1) || (test_mode_sel == 2'h2);
      // every entry into mode 4 restarts the order, even straight from mode 7
      tm4_on_reg <= (test_mode_sel == 2'h1);
      if (test_mode_sel == 2'h1) begin
        tm4_sym_t2 <= tm4_on_reg ? ~tm4_sym_t2 : test_reg[`LPC_ORDER];
      end else begin
        tm4_sym_t2 <= test_reg[`LPC_ORDER];
      end
      tm7_data <= (test_mode_sel == 2'h2) ? test_reg[`LPC_TM7_HI:0] : 8'h00;
    end
  end

  // training duration in milliseconds, saturates at 255
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      training_reg <= 1'b0;
      train_cyc_reg <= 32'h0000_0000;
      train_ms_reg <= 8'h00;
    end else if (clk_en) begin
      if (link_up_start) begin
        training_reg <= 1'b1;
        train_cyc_reg <= 32'h0000_0000;
        train_ms_reg <= 8'h00;
      end else if (training_reg) begin
        if (training_done) begin
          training_reg <= 1'b0;
        end else if (train_cyc_reg == MS_CYC - 1) begin
          train_cyc_reg <= 32'h0000_0000;
          if (train_ms_reg != 8'hff) begin
            train_ms_reg <= train_ms_reg + 8'h01;
          end
        end else begin
          train_cyc_reg <= train_cyc_reg + 32'h0000_0001;
        end
      end
    end
  end

  // checks
  sequence s_wr_phyctl;
    clk_en && reg_wr && reg_addr == `LPC_OFS_PHYCTL;
  endsequence
  AST_FORCE: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && phyctl_reg[`LPC_FRC_EN] |=> !clk_en || link_stat == $past(phyctl_reg[`LPC_FRC_VAL]))
    else $error("forced link status not applied");
  AST_NOFORCE: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && !phyctl_reg[`LPC_FRC_EN] |=> !clk_en || link_stat == $past(link_stat_raw))
    else $error("link status not following derived value");
  AST_RSV_PHY: assert property (@(posedge sys_clk) disable iff (reset)
    s_wr_phyctl |=> phyctl_reg[15] == 1'b0)
    else $error("reserved bit stored");
  AST_TXW: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && tx_wake_req |=> tx_code_vld && tx_code == $past(code_sel_reg[`LPC_TXW_HI:`LPC_TXW_LO]))
    else $error("wrong wake code sent");
  AST_TXS: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && tx_sleep_req && !tx_wake_req |=> tx_code == $past(code_sel_reg[`LPC_TXS_HI:`LPC_TXS_LO]))
    else $error("wrong sleep code sent");
  AST_WAKE_MATCH: assert property (@(posedge sys_clk) disable iff (reset)
    wake_hit |-> $past(rx_code) == $past(code_sel_reg[`LPC_RXW_HI:`LPC_RXW_LO]))
    else $error("wake flagged on wrong code");
  AST_SLEEP_MATCH: assert property (@(posedge sys_clk) disable iff (reset)
    sleep_hit |-> $past(rx_code) == $past(code_sel_reg[`LPC_RXS_HI:`LPC_RXS_LO]))
    else $error("sleep flagged on wrong code");
  AST_WAKE_CMD: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && wake_hit |=> rx_wake_cmd)
    else $error("wake command lost");
  AST_SLEEP_CMD: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && sleep_hit |=> rx_sleep_cmd)
    else $error("sleep command lost");
  AST_MINLOAD: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && link_up_start |=> wait_reg == LPC_MIN && unit_cnt_reg == {8'h00, $past(phyctl_reg[7:0])})
    else $error("min wait not loaded");
  AST_TM7: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && test_mode_sel == 2'h2 |=> tm7_data == $past(test_reg[7:0]))
    else $error("mode 7 data wrong");
  AST_TRAIN_RD: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && reg_rd && reg_addr == `LPC_OFS_TRAIN |=> reg_rdata == {8'h00, $past(train_ms_reg)})
    else $error("training time readback wrong");
  // link-up wait steps and test mode 4 entry
  sequence s_min_end;
    clk_en && !link_up_start && wait_reg == LPC_MIN && unit_cnt_reg == 16'h0000;
  endsequence
  sequence s_max_end;
    clk_en && !link_up_start && wait_reg == LPC_MAX && unit_cnt_reg == 16'h0000;
  endsequence
  sequence s_tm4_enter;
    clk_en && test_mode_sel == 2'h1 && !tm4_on_reg;
  endsequence
  AST_MAXLOAD: assert property (@(posedge sys_clk) disable iff (reset)
    s_min_end |=> wait_reg == LPC_MAX && minwait_done && unit_cnt_reg == $past(maxwait_reg))
    else $error("max wait not loaded");
  AST_MAXDONE: assert property (@(posedge sys_clk) disable iff (reset)
    s_max_end |=> wait_reg == LPC_DONE && maxwait_expired)
    else $error("max wait end not flagged");
  AST_TM4_START: assert property (@(posedge sys_clk) disable iff (reset)
    s_tm4_enter |=> tm4_sym_t2 == $past(test_reg[`LPC_ORDER]))
    else $error("mode 4 first symbol wrong");
  AST_TM4_TOGGLE: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && test_mode_sel == 2'h1 && tm4_on_reg |=> tm4_sym_t2 != $past(tm4_sym_t2))
    else $error("mode 4 symbols not alternating");
  AST_RSV_CODE: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && reg_wr && reg_addr == `LPC_OFS_CODE_SEL |=> code_sel_reg == ($past(reg_wdata) & `LPC_MSK_CODE_SEL))
    else $error("code select write wrong");
  AST_RSV_THRESH: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && reg_wr && reg_addr == `LPC_OFS_THRESH |=> thresh_reg == ($past(reg_wdata) & `LPC_MSK_THRESH))
    else $error("threshold write wrong");
  AST_ZERO_TH: assert property (@(posedge sys_clk) disable iff (reset)
    wake_hit |-> $past(thresh_reg[`LPC_WTH_HI:`LPC_WTH_LO]) != 7'h00)
    else $error("wake flagged with zero threshold");
endmodule : lpc_regs
`default_nettype wire

// >>> dv/lpc_peer.sv
`timescale 1ns/100ps
`default_nettype none
// far-end transceiver model: emits one code group per cycle while asked
module lpc_peer (
  input wire logic sys_clk, // core clock
  input wire logic reset, // async reset
  input wire logic send, // emit a code group this cycle
  input wire lpc_pkg::lpc_code_t send_code, // code group to emit
  output logic rx_code_vld, // code group valid
  output lpc_pkg::lpc_code_t rx_code // code group on the line
);
  import lpc_pkg::*;
  // between groups the code lines flip so a stale value never looks valid
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rx_code_vld <= 1'b0;
      rx_code <= 3'h0;
    end else begin
      rx_code_vld <= send;
      rx_code <= send ? send_code : ~rx_code;
    end
  end
endmodule : lpc_peer
`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import lpc_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  lpc_word_t reg_wdata = 16'h0000;
  logic reg_wr = 1'b0, reg_rd = 1'b0, tx_wake_req = 1'b0, tx_sleep_req = 1'b0, send = 1'b0;
  logic link_up_start = 1'b0, link_stat_raw = 1'b0, training_done = 1'b0, clk_en = 1'b1;
  logic [1:0] test_mode_sel = 2'h0;
  lpc_code_t send_code = 3'h0, rx_code, tx_code;
  lpc_word_t reg_rdata;
  logic rx_code_vld, tx_code_vld, rx_wake_cmd, rx_sleep_cmd, minwait_done, maxwait_expired;
  logic link_stat, tm4_sym_t2, tm_active;
  logic [7:0] tm7_data;
  int n_fail = 0, num_checks = 0;
  logic [15:0] adr [6] = '{16'h0514, 16'h0515, 16'h0518, 16'h0519, 16'h0531, 16'h0543};
  logic [15:0] rst [6] = '{16'h08e3, 16'h0808, 16'h17ce, 16'h003d, 16'h0000, 16'h0000};
  logic [15:0] msk [6] = '{16'h0fff, 16'h7f7f, 16'hffff, 16'h7fff, 16'h01ff, 16'h0000};

  // 25 mhz core clock
  always #20 sys_clk = ~sys_clk;

  lpc_regs #(.UNIT_CYC(4), .MS_CYC(10)) dut (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_wake_req(tx_wake_req), .tx_sleep_req(tx_sleep_req), .rx_code_vld(rx_code_vld), .rx_code(rx_code),
    .link_up_start(link_up_start), .link_stat_raw(link_stat_raw), .training_done(training_done),
    .test_mode_sel(test_mode_sel), .tx_code_vld(tx_code_vld), .tx_code(tx_code), .rx_wake_cmd(rx_wake_cmd),
    .rx_sleep_cmd(rx_sleep_cmd), .minwait_done(minwait_done), .maxwait_expired(maxwait_expired),
    .link_stat(link_stat), .tm4_sym_t2(tm4_sym_t2), .tm7_data(tm7_data), .tm_active(tm_active));

  lpc_peer peer (.sys_clk(sys_clk), .reset(reset), .send(send), .send_code(send_code),
    .rx_code_vld(rx_code_vld), .rx_code(rx_code));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input lpc_word_t d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rchk(input logic [15:0] a, input lpc_word_t exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rchk

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : settle

  // peer sends n copies of one code group back to back
  task automatic run(input lpc_code_t c, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      send <= 1'b1;
      send_code <= c;
    end
    @(posedge sys_clk);
    send <= 1'b0;
  endtask : run

  task automatic pulses(input logic [15:0] ew, input logic [15:0] es);
    logic [15:0] w, s;
    w = 16'h0000;
    s = 16'h0000;
    repeat (5) begin
      @(posedge sys_clk);
      #1;
      w = w + {15'h0000, rx_wake_cmd};
      s = s + {15'h0000, rx_sleep_cmd};
    end
    chk(w, ew);
    chk(s, es);
  endtask : pulses

  task automatic test_regs;
    for (int i = 0; i < 6; i++) rchk(adr[i], rst[i]);
    rchk(16'h0516, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      wr(adr[i], 16'hffff);
      rchk(adr[i], msk[i]);
      wr(adr[i], rst[i]);
    end
    $display("test regs done");
  endtask : test_regs

  task automatic test_tx;
    wr(16'h0514, 16'h0ab1);
    tx_sleep_req <= 1'b1;
    settle(2);
    chk({12'h000, tx_code_vld, tx_code}, 16'h000a);
    @(posedge sys_clk);
    tx_wake_req <= 1'b1;
    settle(2);
    chk({12'h000, tx_code_vld, tx_code}, 16'h000d);
    @(posedge sys_clk);
    tx_wake_req <= 1'b0;
    tx_sleep_req <= 1'b0;
    settle(2);
    chk({12'h000, tx_code_vld, tx_code}, 16'h0000);
    $display("test tx done");
  endtask : test_tx

  task automatic test_rx;
    wr(16'h0515, 16'h0304);
    run(3'h6, 2);
    run(3'h7, 1);
    run(3'h6, 2);
    pulses(16'h0000, 16'h0000);
    run(3'h6, 1);
    pulses(16'h0001, 16'h0000);
    run(3'h1, 3);
    run(3'h6, 1);
    pulses(16'h0000, 16'h0000);
    run(3'h1, 4);
    pulses(16'h0000, 16'h0001);
    $display("test rx done");
  endtask : test_rx

  task automatic test_link;
    wr(16'h0519, 16'h083d);
    settle(2);
    chk({15'h0000, link_stat}, 16'h0000);
    wr(16'h0519, 16'h0c3d);
    settle(2);
    chk({15'h0000, link_stat}, 16'h0001);
    @(posedge sys_clk);
    link_stat_raw <= 1'b1;
    wr(16'h0519, 16'h043d);
    settle(2);
    chk({15'h0000, link_stat}, 16'h0000);
    wr(16'h0519, 16'h003d);
    settle(2);
    chk({15'h0000, link_stat}, 16'h0001);
    $display("test link done");
  endtask : test_link

  task automatic test_tm;
    for (int o = 0; o < 2; o++) begin
      wr(16'h0531, {7'h00, o[0], 8'ha5});
      test_mode_sel <= 2'h1;
      settle(1);
      chk({15'h0000, tm4_sym_t2}, {15'h0000, o[0]});
      settle(1);
      chk({15'h0000, tm4_sym_t2}, {15'h0000, ~o[0]});
      @(posedge sys_clk);
      test_mode_sel <= 2'h2;
      settle(2);
      chk({7'h00, tm_active, tm7_data}, 16'h01a5);
      // straight back to mode 4 must restart the order
      @(posedge sys_clk);
      test_mode_sel <= 2'h1;
      settle(1);
      chk({15'h0000, tm4_sym_t2}, {15'h0000, o[0]});
      @(posedge sys_clk);
      test_mode_sel <= 2'h0;
      settle(2);
      chk({7'h00, tm_active, tm7_data}, 16'h0000);
    end
    $display("test modes done");
  endtask : test_tm

  task automatic test_wait;
    int kmin, kmax;
    wr(16'h0519, 16'h0002);
    wr(16'h0518, 16'h0003);
    @(posedge sys_clk);
    link_up_start <= 1'b1;
    @(posedge sys_clk);
    link_up_start <= 1'b0;
    kmin = 0;
    kmax = 0;
    for (int k = 1; k < 40; k++) begin
      #1;
      if (minwait_done !== 1'b1) kmin = k;
      if (maxwait_expired !== 1'b1) kmax = k;
      @(posedge sys_clk);
      training_done <= (k == 35);
    end
    @(posedge sys_clk);
    training_done <= 1'b0;
    chk({15'h0000, kmin >= 6 && kmin <= 9}, 16'h0001);
    chk({15'h0000, kmax >= 18 && kmax <= 22}, 16'h0001);
    rchk(16'h0543, 16'h0003);
    rchk(16'h0540, 16'h0003);
    $display("test wait done");
  endtask : test_wait

  // with the clock enable low neither a write nor a read is taken
  task automatic test_freeze;
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr(16'h0518, 16'h1234);
    rchk(16'h0518, 16'h0000);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    rchk(16'h0518, 16'h17ce);
    $display("test freeze done");
  endtask : test_freeze

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  // main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    test_regs();
    test_tx();
    test_rx();
    test_link();
    test_freeze();
    test_tm();
    test_wait();
    close_out();
  end

  // watchdog: whole run needs well under 1000 cycles
  initial begin
    #(40 * 4000);
    n_fail++;
    close_out();
  end
endmodule : tb_top
`default_nettype wire
